// ===== rtl/shs_cfg.svh
// homing sequencer register map, option bit positions, reset values and timing
// How it works
// [R1] codes -18/-17 drive positive/negative into the stop and home at the stop
// [R2] stop means i2t rose 50 percent, or torque reached threshold in torque mode
// [R3] codes -1/-2 find the stop, then home on next index positive/negative
// [R4] codes 18/17 search positive/negative to the limit, then crawl back
// [R5] limit homing without index homes at the limit switch falling edge
// [R6] codes 1/2 find the limit, then home on next index negative/positive
// [R7] codes 23/27 search positive/negative for reference, crawl back, home on fall
// [R8] hitting the limit before the reference switch reverses the search
// [R9] codes 7/11 find reference as 23/27, then home on index negative/positive
// [R10] codes -23/-27 first run to travel end positive/negative, then seek reference
// [R11] several switches on reference input: last one in search direction wins
// [R12] codes 32/33 search negative/positive and home on first index pulse
// [R13] code 34 makes no move and sets present position to zero; with return option set it still enters ST_RETURN and moves to zero
// [R14] homing-on-enable starts only on the first enable after power-up
// [R15] return option moves to home at running speed after reference found
// [R16] auxiliary option takes the index from the secondary encoder connector
// [R17] timeout supervision checks elapsed time every 10 ms, errors when exceeded
// [R18] without commutation signals, auto start after commutation found unless suppressed
// [R19] reference switch read as normally closed or normally open by option
// [R20] search distance limit raises error when nothing found within it
// [R21] start-position offset shifts actual position; move only with return option
// [R22] master-axis synchronisation suppressed during homing when option set
// [R23] successful homing sets a done status bit, also driven to a pin
// [R24] homing started over fieldbus makes no follow-up move to home
// [R25] timeout or distance error stops motion, done stays clear, error held
`ifndef SHS_CFG_SVH
`define SHS_CFG_SVH
`define SHS_A_CTRL 8'h00
`define SHS_A_CFG 8'h04
`define SHS_A_TOUT 8'h08
`define SHS_A_DIST 8'h0C
`define SHS_A_OFS 8'h10
`define SHS_A_TORQ 8'h14
`define SHS_A_STAT 8'h18
`define SHS_A_POS 8'h1C
`define SHS_B_START 0
`define SHS_B_FBUS 1
`define SHS_B_ONEN 8
`define SHS_B_RET 9
`define SHS_B_AUX 10
`define SHS_B_TOEN 11
`define SHS_B_NOCOMM 12
`define SHS_B_NC 13
`define SHS_B_DISTEN 14
`define SHS_B_NOSYNC 15
`define SHS_B_TQMODE 16
`define SHS_B_NOCSIG 17
`define SHS_CFG_RST 32'h0000_0022
`define SHS_TOUT_RST 32'h0000_1770
`define SHS_DIST_RST 32'hFFFF_FFFF
`define SHS_TICK_MS 10
`define SHS_CLK_KHZ 125000
`define SHS_TICK_CYC (`SHS_TICK_MS * `SHS_CLK_KHZ)
`define SHS_STOP_RISE_PCT 50
`endif

// ===== rtl/shs_homing.sv
// homing sequencer: method decode, search/crawl/index sequencing, AXI4-Lite registers
`timescale 1ns/1ps
`include "shs_cfg.svh"
module shs_homing #(
  parameter int unsigned TICK_CYC = `SHS_TICK_CYC
) (
  input logic aclk,
  input logic aresetn,
  input logic [7:0] awaddr,
  input logic awvalid,
  output logic awready,
  input logic [31:0] wdata,
  input logic [3:0] wstrb,
  input logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input logic bready,
  input logic [7:0] araddr,
  input logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input logic rready,
  input logic [31:0] pos_act,
  input logic [15:0] i2t_lvl,
  input logic [15:0] torque_act,
  input logic drive_en,
  input logic comm_found,
  input logic move_done,
  input logic lim_pos_pin,
  input logic lim_neg_pin,
  input logic ref_sw_pin,
  input logic index_pin,
  input logic sec_index_pin,
  output shs_pkg::shs_mv_t mv,
  output logic pos_set,
  output logic [31:0] pos_set_val,
  output logic homing_done,
  output logic sync_inhibit
);
  import shs_pkg::*;

  if (TICK_CYC < 2) begin : g_chk
    $error("TICK_CYC must be at least 2");
  end

  function automatic shs_meth_t decode(input logic [7:0] c);
    shs_meth_t r;
    r = '{TGT_NONE, 1'b0, 1'b0, 1'b0, 1'b1};
    unique case (c)
      M_N18: r = '{TGT_STOP, 1'b1, 1'b0, 1'b0, 1'b1}; // see [R1]
      M_N17: r = '{TGT_STOP, 1'b0, 1'b0, 1'b0, 1'b1}; // see [R1]
      M_N1: r = '{TGT_STOP, 1'b0, 1'b1, 1'b1, 1'b1}; // see [R3]
      M_N2: r = '{TGT_STOP, 1'b1, 1'b1, 1'b0, 1'b1}; // see [R3]
      M_P18: r = '{TGT_LIM, 1'b1, 1'b0, 1'b0, 1'b1}; // see [R4]
      M_P17: r = '{TGT_LIM, 1'b0, 1'b0, 1'b0, 1'b1}; // see [R4]
      M_P1: r = '{TGT_LIM, 1'b1, 1'b1, 1'b0, 1'b1}; // see [R6]
      M_P2: r = '{TGT_LIM, 1'b0, 1'b1, 1'b1, 1'b1}; // see [R6]
      M_P23: r = '{TGT_REF, 1'b1, 1'b0, 1'b0, 1'b1}; // see [R7]
      M_P27: r = '{TGT_REF, 1'b0, 1'b0, 1'b0, 1'b1}; // see [R7]
      M_P7: r = '{TGT_REF, 1'b1, 1'b1, 1'b0, 1'b1}; // see [R9]
      M_P11: r = '{TGT_REF, 1'b0, 1'b1, 1'b1, 1'b1}; // see [R9]
      M_N23: r = '{TGT_END, 1'b1, 1'b0, 1'b0, 1'b1}; // see [R10]
      M_N27: r = '{TGT_END, 1'b0, 1'b0, 1'b0, 1'b1}; // see [R10]
      M_P32: r = '{TGT_IDX, 1'b0, 1'b0, 1'b0, 1'b1}; // see [R12]
      M_P33: r = '{TGT_IDX, 1'b1, 1'b0, 1'b0, 1'b1}; // see [R12]
      M_P34: r = '{TGT_NONE, 1'b0, 1'b0, 1'b0, 1'b1}; // see [R13]
      default: r.ok = 1'b0;
    endcase
    return r;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) r[i*8 +: 8] = n[i*8 +: 8];
    end
    return r;
  endfunction

  function automatic logic [31:0] absdiff(input logic [31:0] a, input logic [31:0] b);
    logic [31:0] d;
    d = a - b;
    return d[31] ? 32'h0 - d : d;
  endfunction

  // bus side registers
  logic aw_rdy_q, bvalid_q, ar_rdy_q, rvalid_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;
  logic [31:0] cfg_q, tout_q, dist_q, ofs_q, torq_q;

  // sequencer registers
  shs_st_t st_q, st_d;
  shs_meth_t m_q;
  logic dir_q, dir_d;
  logic fb_q, done_q, done_d, err_to_q, err_dist_q;
  logic en_prev_q, en_seen_q, comm_prev_q;
  logic [16:0] thr_q;
  logic [31:0] start_pos_q, tick_q, el_q;
  shs_mv_t mv_q;
  logic pos_set_q, sync_q;
  logic [31:0] pos_val_q;
  logic [4:0] pin_s1_q, pin_s2_q, pin_p_q;
  logic home_now;

  // pins are asynchronous to aclk; edges are taken only between stage two and its copy
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_s1_q <= 5'h00;
      pin_s2_q <= 5'h00;
      pin_p_q <= 5'h00;
    end else begin
      pin_s1_q <= {sec_index_pin, index_pin, ref_sw_pin, lim_neg_pin, lim_pos_pin};
      pin_s2_q <= pin_s1_q;
      pin_p_q <= pin_s2_q;
    end
  end

  wire lim_p = pin_s2_q[0];
  wire lim_n = pin_s2_q[1];
  wire nc = cfg_q[`SHS_B_NC];
  wire ref_act = pin_s2_q[2] ^ nc; // see [R19]
  wire ref_was = pin_p_q[2] ^ nc;
  wire ref_fall = ref_was & ~ref_act;
  wire aux = cfg_q[`SHS_B_AUX];
  wire idx_ev = aux ? (pin_s2_q[4] & ~pin_p_q[4]) : (pin_s2_q[3] & ~pin_p_q[3]); // see [R16]
  wire lim_ahead = dir_q ? lim_p : lim_n;
  // while crawling the direction is already reversed, so the hit switch lies behind
  wire lim_back_fall = dir_q ? (pin_p_q[1] & ~lim_n) : (pin_p_q[0] & ~lim_p);

  // stop detection
  wire tq_mode = cfg_q[`SHS_B_TQMODE];
  wire [16:0] rise = 17'((32'(i2t_lvl) * `SHS_STOP_RISE_PCT) / 100);
  wire stop_ev = tq_mode ? (torque_act >= torq_q[15:0]) : ({1'b0, i2t_lvl} >= thr_q); // see [R2]

  // bus decode
  wire wr_go = awvalid & wvalid & ~aw_rdy_q & ~bvalid_q;
  wire rd_go = arvalid & ~ar_rdy_q & ~rvalid_q;
  wire wr_map = (awaddr[7:5] == 3'h0);
  wire rd_map = (araddr[7:5] == 3'h0);
  wire [7:0] wa = {awaddr[7:2], 2'b00};
  wire [7:0] ra = {araddr[7:2], 2'b00};
  wire wr_ctrl = wr_go & (wa == `SHS_A_CTRL) & wstrb[0];
  wire [31:0] stat = {28'h0, err_dist_q, err_to_q, (st_q != ST_IDLE), done_q};
  wire [31:0] rd_val = (ra == `SHS_A_CFG) ? cfg_q :
                       (ra == `SHS_A_TOUT) ? tout_q :
                       (ra == `SHS_A_DIST) ? dist_q :
                       (ra == `SHS_A_OFS) ? ofs_q :
                       (ra == `SHS_A_TORQ) ? torq_q :
                       (ra == `SHS_A_STAT) ? stat :
                       (ra == `SHS_A_POS) ? pos_act : 32'h0;

  // start sources
  wire idle = (st_q == ST_IDLE);
  wire sw_start = wr_ctrl & wdata[`SHS_B_START];
  wire sw_fb = wdata[`SHS_B_FBUS];
  wire en_rise = drive_en & ~en_prev_q;
  wire auto_en = en_rise & ~en_seen_q & cfg_q[`SHS_B_ONEN]; // see [R14]
  wire comm_rise = comm_found & ~comm_prev_q;
  // see [R18]
  wire auto_comm = comm_rise & cfg_q[`SHS_B_NOCSIG] & ~cfg_q[`SHS_B_NOCOMM];
  shs_meth_t meth;
  assign meth = decode(cfg_q[7:0]);
  wire start_go = idle & (sw_start | auto_en | auto_comm) & meth.ok;
  wire fb_now = start_go ? (sw_start & sw_fb) : fb_q;
  wire ret_go = cfg_q[`SHS_B_RET] & ~fb_now; // see [R15] [R24]

  // supervision
  wire tick = (tick_q == 32'(TICK_CYC - 1)); // see [R17]
  wire to_ev = ~idle & tick & cfg_q[`SHS_B_TOEN] & (el_q >= tout_q); // see [R17]
  wire seeking = ~idle & (st_q != ST_RETURN);
  // see [R20]
  wire dist_ev = seeking & cfg_q[`SHS_B_DISTEN] & (absdiff(pos_act, start_pos_q) > dist_q);
  wire err_ev = to_ev | dist_ev;
  wire crawl_fall = (m_q.tgt == TGT_LIM) ? lim_back_fall : ref_fall;

  always_comb begin
    st_d = st_q;
    dir_d = dir_q;
    home_now = 1'b0;
    unique case (st_q)
      ST_IDLE: begin
        if (start_go) begin
          dir_d = meth.dir;
          if (meth.tgt == TGT_NONE) home_now = 1'b1; // see [R13]
          else if (meth.tgt == TGT_END) st_d = ST_PRE; // see [R10]
          else st_d = ST_SEARCH;
        end
      end
      ST_PRE: begin
        // end of travel is a limit or a stop; the reference seen first on the way
        // back is the last one in the original direction
        if (lim_ahead || stop_ev) begin // see [R10] [R11]
          st_d = ST_SEARCH;
          dir_d = ~dir_q;
        end
      end
      ST_SEARCH: begin
        if (m_q.tgt == TGT_STOP) begin
          if (stop_ev && m_q.use_idx) begin // see [R3]
            st_d = ST_INDEX;
            dir_d = m_q.idx_dir;
          end else if (stop_ev) begin
            home_now = 1'b1; // see [R1]
          end
        end else if (m_q.tgt == TGT_LIM) begin
          if (lim_ahead) begin // see [R4]
            st_d = ST_CRAWL;
            dir_d = ~dir_q;
          end
        end else if (m_q.tgt == TGT_IDX) begin
          if (idx_ev) home_now = 1'b1; // see [R12]
        end else if (ref_act) begin // see [R7]
          st_d = ST_CRAWL;
          dir_d = ~dir_q;
        end else if (lim_ahead && m_q.tgt == TGT_REF) begin
          dir_d = ~dir_q; // see [R8]
        end
      end
      ST_CRAWL: begin
        if (crawl_fall && m_q.use_idx) begin // see [R6] [R9]
          st_d = ST_INDEX;
          dir_d = m_q.idx_dir;
        end else if (crawl_fall) begin
          home_now = 1'b1; // see [R5] [R7]
        end
      end
      ST_INDEX: begin
        if (idx_ev) home_now = 1'b1; // see [R3] [R6] [R9]
      end
      ST_RETURN: begin
        if (move_done) st_d = ST_IDLE;
      end
    endcase
    if (home_now) st_d = ret_go ? ST_RETURN : ST_IDLE;
    if (err_ev) st_d = ST_IDLE; // see [R25]
  end

  // done is set on the finishing step; a start in the same cycle loses to it
  always_comb begin
    done_d = done_q;
    if (start_go) done_d = 1'b0;
    if (!err_ev && ((home_now && !ret_go) || (st_q == ST_RETURN && move_done))) begin
      done_d = 1'b1; // see [R23]
    end
  end

  shs_mv_t mv_d;
  always_comb begin
    mv_d.run = (st_d != ST_IDLE);
    mv_d.dir_pos = dir_d;
    mv_d.spd = (st_d == ST_RETURN) ? SPD_RUN :
               ((st_d == ST_CRAWL) || (st_d == ST_INDEX)) ? SPD_CRAWL : SPD_SEARCH;
    mv_d.goto_zero = (st_d == ST_RETURN); // see [R15] [R21]
  end

  // motion output only reaches home physically via return; offset only shifts position
  wire [31:0] home_val = (idle ? (meth.tgt == TGT_NONE) : 1'b0) ? 32'h0 : 32'h0 - ofs_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= ST_IDLE;
      m_q <= '{TGT_NONE, 1'b0, 1'b0, 1'b0, 1'b0};
      dir_q <= 1'b0;
      fb_q <= 1'b0;
      done_q <= 1'b0;
      mv_q <= '{1'b0, 1'b0, SPD_SEARCH, 1'b0};
      pos_set_q <= 1'b0;
      pos_val_q <= 32'h0;
      sync_q <= 1'b0;
    end else begin
      st_q <= st_d;
      dir_q <= dir_d;
      fb_q <= fb_now;
      done_q <= done_d;
      mv_q <= mv_d;
      pos_set_q <= home_now & ~err_ev;
      if (home_now) pos_val_q <= home_val; // see [R13] [R21]
      if (start_go) m_q <= meth;
      sync_q <= (st_d != ST_IDLE) & cfg_q[`SHS_B_NOSYNC]; // see [R22]
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      err_to_q <= 1'b0;
      err_dist_q <= 1'b0;
      en_prev_q <= 1'b0;
      en_seen_q <= 1'b0;
      comm_prev_q <= 1'b0;
      thr_q <= 17'h1FFFF;
      start_pos_q <= 32'h0;
      tick_q <= 32'h0;
      el_q <= 32'h0;
    end else begin
      en_prev_q <= drive_en;
      comm_prev_q <= comm_found;
      if (en_rise) en_seen_q <= 1'b1; // see [R14]
      // errors are held until the next start; a new error in that cycle still wins
      if (to_ev) err_to_q <= 1'b1; // see [R25]
      else if (start_go) err_to_q <= 1'b0;
      if (dist_ev) err_dist_q <= 1'b1; // see [R25]
      else if (start_go) err_dist_q <= 1'b0;
      if (start_go) begin
        thr_q <= {1'b0, i2t_lvl} + rise; // see [R2]
        start_pos_q <= pos_act;
        tick_q <= 32'h0;
        el_q <= 32'h0;
      end else if (!idle) begin
        tick_q <= tick ? 32'h0 : tick_q + 32'h1;
        if (tick) el_q <= el_q + 32'h1;
      end
    end
  end

  // AXI4-Lite slave: address and data are taken together, one access of each kind
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_rdy_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= 2'b00;
      ar_rdy_q <= 1'b0;
      rvalid_q <= 1'b0;
      rresp_q <= 2'b00;
      rdata_q <= 32'h0;
      cfg_q <= `SHS_CFG_RST;
      tout_q <= `SHS_TOUT_RST;
      dist_q <= `SHS_DIST_RST;
      ofs_q <= 32'h0;
      torq_q <= 32'h0;
    end else begin
      aw_rdy_q <= wr_go;
      if (wr_go) bresp_q <= wr_map ? 2'b00 : 2'b10;
      // a response may only follow the handshake edge, so valid waits for it
      if (aw_rdy_q) bvalid_q <= 1'b1;
      else if (bready) bvalid_q <= 1'b0;
      ar_rdy_q <= rd_go;
      if (rd_go) begin
        rresp_q <= rd_map ? 2'b00 : 2'b10;
        rdata_q <= rd_map ? rd_val : 32'h0;
      end
      if (ar_rdy_q) rvalid_q <= 1'b1;
      else if (rready) rvalid_q <= 1'b0;
      if (wr_go && wa == `SHS_A_CFG) cfg_q <= merge(cfg_q, wdata, wstrb);
      if (wr_go && wa == `SHS_A_TOUT) tout_q <= merge(tout_q, wdata, wstrb);
      if (wr_go && wa == `SHS_A_DIST) dist_q <= merge(dist_q, wdata, wstrb);
      if (wr_go && wa == `SHS_A_OFS) ofs_q <= merge(ofs_q, wdata, wstrb);
      if (wr_go && wa == `SHS_A_TORQ) torq_q <= merge(torq_q, wdata, wstrb);
    end
  end

  assign awready = aw_rdy_q;
  assign wready = aw_rdy_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign arready = ar_rdy_q;
  assign rvalid = rvalid_q;
  assign rresp = rresp_q;
  assign rdata = rdata_q;
  assign mv = mv_q;
  assign pos_set = pos_set_q;
  assign pos_set_val = pos_val_q;
  assign homing_done = done_q;
  assign sync_inhibit = sync_q;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  stop_dir_a: assert property (start_go && cfg_q[7:0] == M_N18 |=> mv.run && mv.dir_pos) // see [R1]
    else $error("stop method -18 did not drive positive");
  stop_home_a: assert property (st_q == ST_SEARCH && m_q.tgt == TGT_STOP && !m_q.use_idx // see [R2]
    && stop_ev && !err_ev |=> pos_set && $past(st_d) != ST_SEARCH)
    else $error("stop detection did not set home");
  lim_crawl_a: assert property (st_q == ST_SEARCH && m_q.tgt == TGT_LIM && lim_ahead // see [R4]
    && !err_ev |=> st_q == ST_CRAWL && mv.spd == SPD_CRAWL && dir_q != $past(dir_q))
    else $error("limit did not turn search into crawl");
  ref_turn_a: assert property (st_q == ST_SEARCH && m_q.tgt == TGT_REF && !ref_act // see [R8]
    && lim_ahead && !err_ev |=> st_q == ST_SEARCH && dir_q != $past(dir_q))
    else $error("limit during reference search did not reverse");
  index_home_a: assert property (st_q == ST_INDEX && idx_ev && !err_ev // see [R6]
    |=> pos_set ##1 !pos_set)
    else $error("index pulse did not home");
  zero_set_a: assert property (start_go && meth.tgt == TGT_NONE && !err_ev // see [R13]
    |=> pos_set && pos_set_val == 32'h0 && !mv.run)
    else $error("code 34 did not set zero in place");
  err_hold_a: assert property (err_to_q && !start_go |=> err_to_q) // see [R25]
    else $error("timeout error dropped without new start");
  err_done_a: assert property (err_ev |=> !mv.run && !homing_done) // see [R25]
    else $error("error left motion running or done set");
  fb_noret_a: assert property (home_now && fb_now && !err_ev |=> !mv.goto_zero) // see [R24]
    else $error("fieldbus start moved to home");
  sync_off_a: assert property (!idle && cfg_q[`SHS_B_NOSYNC] && $stable(cfg_q) // see [R22]
    ##1 !idle |-> sync_inhibit)
    else $error("synchronisation not suppressed during homing");
endmodule

// ===== rtl/shs_pkg.sv
// homing sequencer types
package shs_pkg;
  typedef enum logic [7:0] {
    M_N18 = 8'hEE, M_N17 = 8'hEF, M_N1 = 8'hFF, M_N2 = 8'hFE,
    M_P18 = 8'h12, M_P17 = 8'h11, M_P1 = 8'h01, M_P2 = 8'h02,
    M_P23 = 8'h17, M_P27 = 8'h1B, M_P7 = 8'h07, M_P11 = 8'h0B,
    M_N23 = 8'hE9, M_N27 = 8'hE5, M_P32 = 8'h20, M_P33 = 8'h21, M_P34 = 8'h22
  } shs_code_t;
  typedef enum logic [2:0] {TGT_NONE, TGT_STOP, TGT_LIM, TGT_REF, TGT_END, TGT_IDX} shs_tgt_t;
  typedef struct packed {
    shs_tgt_t tgt;
    logic dir;
    logic use_idx;
    logic idx_dir;
    logic ok;
  } shs_meth_t;
  typedef enum logic [2:0] {ST_IDLE, ST_PRE, ST_SEARCH, ST_CRAWL, ST_INDEX, ST_RETURN} shs_st_t;
  typedef enum logic [1:0] {SPD_SEARCH, SPD_CRAWL, SPD_RUN} shs_spd_t;
  typedef struct packed {
    logic run;
    logic dir_pos;
    shs_spd_t spd;
    logic goto_zero;
  } shs_mv_t;
endpackage

// ===== verif/shs_axis_model.sv
// axis model: position, end stops, limit and reference switches, encoder index
`timescale 1ns/1ps
module shs_axis_model (
  input logic aclk,
  input logic aresetn,
  input shs_pkg::shs_mv_t mv,
  input logic pos_set,
  input logic [31:0] pos_set_val,
  input logic nc,
  input logic aux,
  output logic [31:0] pos_act,
  output logic [15:0] i2t_lvl,
  output logic [15:0] torque_act,
  output logic move_done,
  output logic lim_pos_pin,
  output logic lim_neg_pin,
  output logic ref_sw_pin,
  output logic index_pin,
  output logic sec_index_pin
);
  import shs_pkg::*;
  logic signed [31:0] w_q, w_d, sh_q, step;
  logic [15:0] blk_q;
  logic idx_q, push;
  // world position never jumps on pos_set; only the reported frame shifts
  assign pos_act = w_q + sh_q;
  assign step = (mv.spd == SPD_SEARCH) ? 4 : (mv.spd == SPD_CRAWL) ? 1 : 8;
  assign push = mv.run && (w_q == 2000 && mv.dir_pos || w_q == -2000 && !mv.dir_pos);
  always_comb begin
    w_d = w_q;
    if (mv.run && mv.goto_zero) begin
      w_d = ($signed(pos_act) > 8) ? w_q - 8 : ($signed(pos_act) < -8) ? w_q + 8 : -sh_q;
    end else if (mv.run) begin
      w_d = mv.dir_pos ? w_q + step : w_q - step;
    end
    // hard stops: the motor stalls and load rises instead
    if (w_d > 2000) w_d = 2000;
    if (w_d < -2000) w_d = -2000;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_q <= 0;
      sh_q <= 0;
      blk_q <= 16'h0;
      idx_q <= 1'b0;
    end else begin
      w_q <= w_d;
      sh_q <= pos_set ? pos_set_val - w_d : sh_q;
      blk_q <= push ? blk_q + 16'h1 : 16'h0;
      idx_q <= ((w_d + 4096) >>> 6) != ((w_q + 4096) >>> 6);
    end
  end
  assign i2t_lvl = 16'h64 + blk_q;
  assign torque_act = blk_q;
  assign move_done = mv.goto_zero && pos_act == 32'h0;
  assign lim_pos_pin = w_q >= 1500;
  assign lim_neg_pin = w_q <= -1500;
  assign ref_sw_pin = (w_q >= 300 && w_q <= 400) ^ nc;
  assign index_pin = idx_q & ~aux;
  assign sec_index_pin = idx_q & aux;
endmodule

// ===== verif/testbench.sv
// testbench for the homing sequencer: bus tasks, axis model, method sweep
`timescale 1ns/1ps
`include "shs_cfg.svh"
module testbench;
  import shs_pkg::*;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, pos_act, pos_set_val;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [15:0] i2t_lvl, torque_act;
  logic drive_en, comm_found, move_done, lim_pos_pin, lim_neg_pin, ref_sw_pin;
  logic index_pin, sec_index_pin, pos_set, homing_done, sync_inhibit, nc, aux;
  logic first_dir, saw_gz, saw_si;
  shs_mv_t mv;
  int err_total, check_count;
  logic [7:0] codes [16] = '{8'hEE, 8'hEF, 8'hFF, 8'hFE, 8'h12, 8'h11, 8'h01, 8'h02,
    8'h17, 8'h1B, 8'h07, 8'h0B, 8'hE9, 8'hE5, 8'h20, 8'h21};
  logic [15:0] dirs = 16'h9559;
  shs_homing #(.TICK_CYC(20)) uut (.*);
  shs_axis_model axis (.*);
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      $display("[ERR] %s expected %h seen %h", nm, e, g);
      err_total++;
    end
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
    end while (awready !== 1'b1 && n < 40);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    while (bvalid !== 1'b1 && n < 40) begin
      @(posedge aclk);
      n++;
    end
    chk("bvalid", 32'h1, {31'h0, bvalid});
    chk("bresp", {30'h0, er}, {30'h0, bresp});
  endtask
  task automatic axr(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
    end while (arready !== 1'b1 && n < 40);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1 && n < 40) begin
      @(posedge aclk);
      n++;
    end
    chk("rvalid", 32'h1, {31'h0, rvalid});
    chk("rdata", e, rdata);
    chk("rresp", {30'h0, er}, {30'h0, rresp});
  endtask
  task automatic rst();
    aresetn <= 1'b0;
    drive_en <= 1'b0;
    comm_found <= 1'b0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
  endtask
  task automatic run_m(input logic [31:0] cfg, input logic [7:0] a2, input logic [31:0] d2,
      input logic fb);
    int n;
    n = 0;
    rst();
    axw(`SHS_A_CFG, cfg, 2'b00);
    axw(`SHS_A_OFS, 32'h5, 2'b00);
    axw(a2, d2, 2'b00);
    axw(`SHS_A_CTRL, {30'h0, fb, 1'b1}, 2'b00);
    first_dir = mv.dir_pos;
    saw_gz = 1'b0;
    saw_si = 1'b0;
    while (homing_done !== 1'b1 && n < 9000) begin
      @(posedge aclk);
      n++;
      saw_gz |= mv.goto_zero;
      saw_si |= sync_inhibit;
    end
  endtask
  // a failed run must freeze the axis and keep the error until restarted
  task automatic err_t(input logic [7:0] a, input logic [31:0] d, input logic [31:0] cfg,
      input logic [31:0] e);
    rst();
    axw(a, d, 2'b00);
    axw(`SHS_A_CFG, cfg, 2'b00);
    axw(`SHS_A_CTRL, 32'h1, 2'b00);
    axr(`SHS_A_STAT, 32'h2, 2'b00);
    repeat (80) @(posedge aclk);
    axr(`SHS_A_STAT, e, 2'b00);
    chk("run", 32'h0, {31'h0, mv.run});
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    repeat (80000) @(posedge aclk);
    $display("watchdog expired");
    err_total++;
    print_verdict();
  end
  initial begin
    {awvalid, wvalid, arvalid, drive_en, comm_found, nc, aux, aresetn} = '0;
    {awaddr, araddr, wdata} = '0;
    {bready, rready} = 2'b11;
    wstrb = 4'hF;
    err_total = 0;
    check_count = 0;
    rst();
    axr(`SHS_A_CFG, `SHS_CFG_RST, 2'b00);
    axr(`SHS_A_TOUT, `SHS_TOUT_RST, 2'b00);
    axr(`SHS_A_DIST, `SHS_DIST_RST, 2'b00);
    axr(`SHS_A_STAT, 32'h0, 2'b00);
    axr(8'h20, 32'h0, 2'b10);
    axw(8'h20, 32'h1, 2'b10);
    axw(`SHS_A_OFS, 32'hA5A5_0F0F, 2'b00);
    axr(`SHS_A_OFS, 32'hA5A5_0F0F, 2'b00);
    $display("test registers done");
    for (int i = 0; i < 16; i++) begin
      run_m({24'h0, codes[i]}, `SHS_A_OFS, 32'h5, 1'b0);
      chk("done", 32'h1, {31'h0, homing_done});
      chk("dir", {31'h0, dirs[i]}, {31'h0, first_dir});
      chk("home", 32'hFFFF_FFFB, pos_set_val);
    end
    axr(`SHS_A_STAT, 32'h1, 2'b00);
    axr(`SHS_A_POS, 32'hFFFF_FFFB, 2'b00);
    $display("test methods done");
    run_m(32'h22, `SHS_A_OFS, 32'h5, 1'b0);
    chk("home34", 32'h0, pos_set_val);
    run_m(32'h221, `SHS_A_OFS, 32'h5, 1'b0);
    chk("return", 32'h1, {31'h0, saw_gz});
    run_m(32'h221, `SHS_A_OFS, 32'h5, 1'b1);
    chk("fieldbus", 32'h0, {31'h0, saw_gz});
    aux <= 1'b1;
    run_m(32'h421, `SHS_A_OFS, 32'h5, 1'b0);
    chk("aux", 32'h1, {31'h0, homing_done});
    aux <= 1'b0;
    nc <= 1'b1;
    run_m(32'h2017, `SHS_A_OFS, 32'h5, 1'b0);
    chk("nc", 32'h1, {31'h0, homing_done});
    nc <= 1'b0;
    run_m(32'h1_00EE, `SHS_A_TORQ, 32'h3, 1'b0);
    chk("torque", 32'h1, {31'h0, homing_done});
    // torque mode must stop before the load has risen by half
    chk("torque_lvl", 32'h1, {31'h0, i2t_lvl < 16'h96});
    run_m(32'h8021, `SHS_A_OFS, 32'h5, 1'b0);
    @(posedge aclk);
    chk("sync", 32'h2, {30'h0, saw_si, sync_inhibit});
    $display("test options done");
    err_t(`SHS_A_TOUT, 32'h3, 32'h812, 32'h4);
    err_t(`SHS_A_DIST, 32'h64, 32'h4012, 32'h8);
    $display("test errors done");
    rst();
    axw(`SHS_A_CFG, 32'h121, 2'b00);
    drive_en <= 1'b1;
    repeat (4) @(posedge aclk);
    chk("enable1", 32'h1, {31'h0, mv.run});
    repeat (200) @(posedge aclk);
    drive_en <= 1'b0;
    repeat (2) @(posedge aclk);
    drive_en <= 1'b1;
    repeat (6) @(posedge aclk);
    chk("enable2", 32'h0, {31'h0, mv.run});
    rst();
    axw(`SHS_A_CFG, 32'h2_0021, 2'b00);
    comm_found <= 1'b1;
    repeat (4) @(posedge aclk);
    chk("comm", 32'h1, {31'h0, mv.run});
    rst();
    axw(`SHS_A_CFG, 32'h2_1021, 2'b00);
    comm_found <= 1'b1;
    repeat (4) @(posedge aclk);
    chk("nocomm", 32'h0, {31'h0, mv.run});
    $display("test auto start done");
    print_verdict();
  end
endmodule
